// File: hw/wdio_params.svh
// Offsets, field positions, reset values and timing of the weld discrete I/O
`ifndef WDIO_PARAMS_SVH
`define WDIO_PARAMS_SVH

`define WDIO_ADDR_W 8
`define WDIO_OFS_CTRL 8'h00
`define WDIO_OFS_LAST_STEP 8'h04
`define WDIO_OFS_STATUS 8'h08
`define WDIO_OFS_WELD_COUNT 8'h0c
`define WDIO_OFS_IRQ_STAT 8'h10
`define WDIO_OFS_IRQ_MASK 8'h14

`define WDIO_CTRL_INTERLOCK_SEL 0
`define WDIO_CTRL_INDICATOR_MODE 1
`define WDIO_CTRL_FINISH_PULSE_MODE 2
`define WDIO_CTRL_RST 3'h0
`define WDIO_LAST_STEP_RST 4'h4
`define WDIO_FIRST_STEP 4'h1

`define WDIO_IRQ_FAULT 0
`define WDIO_IRQ_HOLD_END 1
`define WDIO_IRQ_STEP_END 2
`define WDIO_IRQ_EDIT_REJECT 3
`define WDIO_IRQ_W 4

`define WDIO_CLK_HZ 25000000
`define WDIO_HOLD_PULSE_MS 200
`define WDIO_LINE_HZ 50
`define WDIO_LEAD_LINE_CYCLES 2

`endif

// File: hw/wdio_pkg.sv
// Types shared by the weld discrete I/O design
package wdio_pkg;

	typedef struct packed {
		logic step_restart;
		logic weld_enable;
		logic thermostat_ok;
		logic interlock_cnt_rst;
		logic edit_lock;
		logic fault_clear;
	} wdio_pins_t;

	typedef struct packed {
		logic phase1_start;
		logic phase3_end;
		logic current_on;
		logic current_req;
		logic hold_done;
		logic step_advance;
		logic count_up;
		logic error_evt;
		logic start_active;
		logic sched_wr_req;
	} wdio_seq_in_t;

	typedef struct packed {
		logic weld_permit;
		logic current_grant;
		logic sched_wr_en;
		logic count_clear;
		logic [3:0] step_pos;
	} wdio_seq_out_t;

	typedef enum logic [2:0] {
		IL_IDLE = 3'b001,
		IL_LEAD = 3'b010,
		IL_POWER = 3'b100
	} wdio_il_state_t;

endpackage : wdio_pkg

// File: hw/wdio_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module wdio_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : wdio_sync

// File: hw/wdio_timer.sv
// One-shot down counter: busy for LEN cycles after start, done pulse at end
`timescale 1ns/1ns
module wdio_timer #(
	parameter int unsigned LEN = 16,
	parameter int CNT_W = 24
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	output logic busy,
	output logic done
);
	logic [CNT_W-1:0] cnt;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (abort) begin
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			cnt <= CNT_W'(LEN - 1);
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy && cnt == '0) begin
			busy <= 1'b0;
			done <= 1'b1;
		end else begin
			cnt <= busy ? cnt - 1'b1 : cnt;
			done <= 1'b0;
		end
	end
endmodule : wdio_timer

// File: hw/wdio_ctrl.sv
// Discrete input and output logic of the weld controller, with register port
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "wdio_params.svh"
// Function
// - Step restart clears last-step-done and returns stepper to first step
// - Weld current granted only while weld enable input is on
// - Thermostat input off raises the fault output
// - Shared input: hold-off in interlock mode, else weld counter clear
// - Edit lock input on rejects schedule writes; off accepts them
// - Indicator mode on: indicator follows weld current in phases 1-3
// - Indicator mode off: on from phase one start to phase three end
// - Hold finished output asserts when hold interval completes
// - Any detected error asserts the fault output
// - Last-step-done asserts when final stepper step completes
// - Shared output: interlock signal in interlock mode, else count-up
// - Fault clear input deasserts the fault output
// - Interlock output rises two line cycles before weld current
// - Finish pulse mode gives a hold finished pulse of about 200 ms
module wdio_ctrl #(
	parameter int unsigned HOLD_CLKS = int'((64'(`WDIO_HOLD_PULSE_MS)
		* 64'(`WDIO_CLK_HZ)) / 64'd1000),
	parameter int unsigned LEAD_CLKS = int'((64'(`WDIO_LEAD_LINE_CYCLES)
		* 64'(`WDIO_CLK_HZ)) / 64'(`WDIO_LINE_HZ))
) (
	input wire logic clk,
	input wire logic rst,
	input wdio_pkg::wdio_pins_t pins,
	input wdio_pkg::wdio_seq_in_t seq,
	output wdio_pkg::wdio_seq_out_t seq_out,
	input wire logic [`WDIO_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic current_ind,
	output logic hold_end,
	output logic fault,
	output logic step_end,
	output logic shared_out,
	output logic irq
);
	import wdio_pkg::*;

	localparam logic [5:0] PIN_RST = 6'h08;

	wdio_pins_t s;
	wdio_il_state_t il_state;
	logic [2:0] ctrl;
	logic [3:0] last_step;
	logic [15:0] weld_count;
	logic [`WDIO_IRQ_W-1:0] irq_stat;
	logic [`WDIO_IRQ_W-1:0] irq_mask;
	logic [`WDIO_IRQ_W-1:0] irq_evt;
	logic il_mode;
	logic holdoff;
	logic interlock_out;
	logic hold_busy;
	logic lead_start;
	logic lead_busy;
	logic lead_done;
	logic il_abort;
	logic next_hold_end;
	logic step_last;
	logic [31:0] next_rdata;
	logic [3:0] step_pos;
	logic weld_permit;
	logic current_grant;
	logic sched_wr_en;
	logic count_clear;

	wdio_sync #(.W(6), .RST_VAL(PIN_RST)) u_sync (
		.clk(clk),
		.rst(rst),
		.d(pins),
		.q(s)
	);

	function automatic logic hit(input logic [`WDIO_ADDR_W-1:0] a,
		input logic [`WDIO_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign il_mode = ctrl[`WDIO_CTRL_INTERLOCK_SEL];
	assign holdoff = il_mode && s.interlock_cnt_rst;
	assign step_last = (seq_out.step_pos == last_step);

	// Register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= `WDIO_CTRL_RST;
			last_step <= `WDIO_LAST_STEP_RST;
			irq_mask <= '0;
		end else if (wr) begin
			if (hit(addr, `WDIO_OFS_CTRL))
				ctrl <= wdata[2:0];
			if (hit(addr, `WDIO_OFS_LAST_STEP))
				last_step <= wdata[3:0];
			if (hit(addr, `WDIO_OFS_IRQ_MASK))
				irq_mask <= wdata[`WDIO_IRQ_W-1:0];
		end
	end

	// Register reads, data in the following cycle
	always_comb begin
		next_rdata = 32'h0;
		if (hit(addr, `WDIO_OFS_CTRL))
			next_rdata = {29'h0, ctrl};
		else if (hit(addr, `WDIO_OFS_LAST_STEP))
			next_rdata = {28'h0, last_step};
		else if (hit(addr, `WDIO_OFS_STATUS))
			next_rdata = {18'h0, seq_out.step_pos, s,
				shared_out, step_end, fault, hold_end};
		else if (hit(addr, `WDIO_OFS_WELD_COUNT))
			next_rdata = {16'h0, weld_count};
		else if (hit(addr, `WDIO_OFS_IRQ_STAT))
			next_rdata = {28'h0, irq_stat};
		else if (hit(addr, `WDIO_OFS_IRQ_MASK))
			next_rdata = {28'h0, irq_mask};
	end

	always_ff @(posedge clk) begin
		if (rst)
			rdata <= 32'h0;
		else
			rdata <= rd ? next_rdata : 32'h0;
	end

	// Interrupt status, set wins over write-one-to-clear
	assign irq_evt[`WDIO_IRQ_FAULT] = !fault && (!s.thermostat_ok
		|| seq.error_evt);
	assign irq_evt[`WDIO_IRQ_HOLD_END] = seq.hold_done;
	assign irq_evt[`WDIO_IRQ_STEP_END] = seq.step_advance && step_last;
	assign irq_evt[`WDIO_IRQ_EDIT_REJECT] = seq.sched_wr_req && s.edit_lock;

	always_ff @(posedge clk) begin
		if (rst)
			irq_stat <= '0;
		else if (wr && hit(addr, `WDIO_OFS_IRQ_STAT))
			irq_stat <= (irq_stat & ~wdata[`WDIO_IRQ_W-1:0]) | irq_evt;
		else
			irq_stat <= irq_stat | irq_evt;
	end

	always_ff @(posedge clk) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & ~irq_mask);
	end

	// Stepper position and last-step-done
	always_ff @(posedge clk) begin
		if (rst) begin
			step_pos <= `WDIO_FIRST_STEP;
			step_end <= 1'b0;
		end else if (s.step_restart) begin
			step_pos <= `WDIO_FIRST_STEP;
			step_end <= 1'b0;
		end else if (seq.step_advance) begin
			if (step_last) begin
				step_end <= 1'b1;
			end else begin
				step_pos <= step_pos + 4'h1;
			end
		end
	end

	// Fault output
	always_ff @(posedge clk) begin
		if (rst)
			fault <= 1'b0;
		else if (!s.thermostat_ok)
			fault <= 1'b1;
		else if (seq.error_evt)
			fault <= 1'b1;
		else if (s.fault_clear)
			fault <= 1'b0;
	end

	// Schedule edit gate and weld counter
	always_ff @(posedge clk) begin
		if (rst) begin
			sched_wr_en <= 1'b0;
			count_clear <= 1'b0;
			weld_permit <= 1'b0;
			weld_count <= 16'h0;
		end else begin
			sched_wr_en <= seq.sched_wr_req && !s.edit_lock;
			count_clear <= !il_mode && s.interlock_cnt_rst;
			weld_permit <= s.weld_enable;
			if (!il_mode && s.interlock_cnt_rst)
				weld_count <= 16'h0;
			else if (seq.count_up)
				weld_count <= weld_count + 16'h1;
		end
	end

	// Current grant with interlock lead time
	assign lead_start = (il_state == IL_IDLE) && seq.current_req
		&& s.weld_enable && il_mode && !holdoff;
	assign il_abort = !seq.current_req || !s.weld_enable;

	wdio_timer #(.LEN(LEAD_CLKS), .CNT_W(24)) u_lead (
		.clk(clk),
		.rst(rst),
		.start(lead_start),
		.abort(il_abort),
		.busy(lead_busy),
		.done(lead_done)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			il_state <= IL_IDLE;
		end else if (il_abort) begin
			il_state <= IL_IDLE;
		end else begin
			unique case (il_state)
				IL_IDLE: begin
					if (lead_start)
						il_state <= IL_LEAD;
					else if (!il_mode)
						il_state <= IL_POWER;
				end
				IL_LEAD: begin
					if (lead_done)
						il_state <= IL_POWER;
				end
				IL_POWER: begin
					il_state <= IL_POWER;
				end
				default: begin
					il_state <= IL_IDLE;
				end
			endcase
		end
	end

	assign interlock_out = il_mode && (il_state != IL_IDLE);
	assign current_grant = il_state[2];
	assign seq_out = {weld_permit, current_grant, sched_wr_en, count_clear,
		step_pos};

	// Shared output and current indicator
	always_ff @(posedge clk) begin
		if (rst) begin
			shared_out <= 1'b0;
			current_ind <= 1'b0;
		end else begin
			shared_out <= il_mode ? interlock_out : seq.count_up;
			if (ctrl[`WDIO_CTRL_INDICATOR_MODE])
				current_ind <= seq.current_on;
			else if (seq.phase1_start)
				current_ind <= 1'b1;
			else if (seq.phase3_end)
				current_ind <= 1'b0;
		end
	end

	// Hold finished output
	wdio_timer #(.LEN(HOLD_CLKS), .CNT_W(24)) u_hold (
		.clk(clk),
		.rst(rst),
		.start(seq.hold_done),
		.abort(1'b0),
		.busy(hold_busy),
		.done()
	);

	always_comb begin
		next_hold_end = 1'b0;
		if (seq.hold_done || hold_busy)
			next_hold_end = 1'b1;
		else if (!ctrl[`WDIO_CTRL_FINISH_PULSE_MODE])
			next_hold_end = hold_end && seq.start_active;
	end

	always_ff @(posedge clk) begin
		if (rst)
			hold_end <= 1'b0;
		else
			hold_end <= next_hold_end;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_restart_step: assert property (s.step_restart |=>
		!step_end && seq_out.step_pos == `WDIO_FIRST_STEP)
		else $error("restart did not clear stepper");
	a_enable_grant: assert property (!s.weld_enable |=>
		!seq_out.current_grant)
		else $error("current granted without weld enable");
	a_thermo_fault: assert property (!s.thermostat_ok |=> fault)
		else $error("thermostat off without fault");
	a_holdoff_wait: assert property (il_state == IL_IDLE && holdoff
		|=> il_state == IL_IDLE)
		else $error("hold-off did not block weld");
	a_lock_edit: assert property (s.edit_lock |=>
		!seq_out.sched_wr_en)
		else $error("schedule write passed the lock");
	a_ind_follow: assert property (ctrl[`WDIO_CTRL_INDICATOR_MODE]
		&& $stable(ctrl) |=> current_ind == $past(seq.current_on))
		else $error("indicator does not follow current");
	a_ind_span: assert property (!ctrl[`WDIO_CTRL_INDICATOR_MODE]
		&& seq.phase1_start ##1 !ctrl[`WDIO_CTRL_INDICATOR_MODE]
		|-> current_ind)
		else $error("indicator not on from phase one");
	a_hold_end: assert property (seq.hold_done |=> hold_end [*2])
		else $error("hold finished not raised");
	a_error_fault: assert property (seq.error_evt |=> fault)
		else $error("error did not raise fault");
	a_last_step: assert property (seq.step_advance && step_last
		&& !s.step_restart |=> step_end)
		else $error("last step done missing");
	a_shared_count: assert property (!il_mode |=>
		shared_out == $past(seq.count_up))
		else $error("count-up not on shared output");
	a_fault_clear: assert property (s.fault_clear && s.thermostat_ok
		&& !seq.error_evt |=> !fault)
		else $error("fault clear ignored");
	a_lead_first: assert property ($rose(seq_out.current_grant)
		&& il_mode |-> $past(interlock_out, 2))
		else $error("current before interlock lead");
	a_pulse_mode: assert property (ctrl[`WDIO_CTRL_FINISH_PULSE_MODE]
		&& !hold_busy && !seq.hold_done |=> !hold_end)
		else $error("hold finished longer than pulse");

	c_weld_grant: cover property ($rose(seq_out.current_grant));
	c_interlock_lead: cover property (il_mode && lead_done);
	c_last_step: cover property ($rose(step_end));
	c_irq: cover property ($rose(irq));
endmodule : wdio_ctrl

// File: tb/wdio_plc.sv
// Plant-side model driving the discrete weld inputs
`timescale 1ns/1ns
module wdio_plc (
	input wire logic clk,
	output wdio_pkg::wdio_pins_t pins
);
	import wdio_pkg::*;
	// Idle plant: thermostat closed, all else off
	initial pins = 6'h08;
	task drive(input wdio_pins_t p);
		@(posedge clk);
		pins <= p;
	endtask : drive
endmodule : wdio_plc

// File: tb/test_weld_controller_discrete_io.sv
// Self-checking bench of the weld discrete I/O block
`timescale 1ns/1ns
`include "wdio_params.svh"
module test_weld_controller_discrete_io;
	import wdio_pkg::*;
	localparam int HC = 20;
	localparam int LC = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	wdio_pins_t pins, pv;
	wdio_seq_in_t seq = '0;
	wdio_seq_in_t m;
	wdio_seq_out_t so;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, r;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic current_ind, hold_end, fault, step_end, shared_out, irq;
	int fails = 0;
	int checked = 0;
	int n, ls;
	always #20 clk = ~clk;
	wdio_plc plc_u (.clk(clk), .pins(pins));
	wdio_ctrl #(.HOLD_CLKS(HC), .LEAD_CLKS(LC)) dut_u (.clk(clk), .rst(rst),
		.pins(pins), .seq(seq), .seq_out(so), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .current_ind(current_ind),
		.hold_end(hold_end), .fault(fault), .step_end(step_end),
		.shared_out(shared_out), .irq(irq));
	function automatic logic [3:0] exp_pos(input int k, input int last);
		return (1 + k > last) ? 4'(last) : 4'(1 + k);
	endfunction : exp_pos
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task final_report;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		r = rdata;
	endtask : rreg
	task setp;
		plc_u.drive(pv);
		tick(5);
	endtask : setp
	task pulse(input wdio_seq_in_t p);
		@(posedge clk);
		seq <= seq | p;
		@(posedge clk);
		seq <= seq & ~p;
		#1;
	endtask : pulse
	logic hang = 1'b0;
	initial begin
		for (int i = 0; i < 100000 && !hang; i++)
			@(posedge clk);
		fails++;
		final_report;
	end
	initial begin
		pv = 6'h08;
		n = $urandom(232);
		tick(20);
		rst <= 1'b0;
		tick(1);
		chk("step_pos", so.step_pos, 4'h1);
		chk("outs", {current_ind, hold_end, fault, step_end, shared_out,
			irq}, 0);
		rreg(`WDIO_OFS_CTRL);
		chk("ctrl", r, 32'h0);
		rreg(`WDIO_OFS_LAST_STEP);
		chk("last_step", r, 32'h4);
		rreg(8'h3c);
		chk("unmapped", r, 32'h0);
		$display("reset test done");
		wreg(`WDIO_OFS_IRQ_MASK, 32'h0);
		ls = 2 + ($urandom % 4);
		wreg(`WDIO_OFS_LAST_STEP, ls);
		m = '0;
		m.step_advance = 1'b1;
		for (int k = 1; k <= 6; k++) begin
			pulse(m);
			chk("step_pos", so.step_pos, exp_pos(k, ls));
		end
		tick(1);
		chk("step_end", step_end, 1'b1);
		pv.step_restart = 1'b1;
		setp;
		chk("restart pos", so.step_pos, 4'h1);
		chk("restart end", step_end, 1'b0);
		pv.step_restart = 1'b0;
		setp;
		$display("stepper test done");
		wreg(`WDIO_OFS_IRQ_STAT, 32'hf);
		pv.thermostat_ok = 1'b0;
		setp;
		chk("fault", fault, 1'b1);
		rreg(`WDIO_OFS_IRQ_STAT);
		chk("irq_stat", r[0], 1'b1);
		chk("irq", irq, 1'b1);
		wreg(`WDIO_OFS_IRQ_MASK, 32'hf);
		tick(2);
		chk("irq masked", irq, 1'b0);
		pv.thermostat_ok = 1'b1;
		pv.fault_clear = 1'b1;
		setp;
		chk("fault clr", fault, 1'b0);
		pv.fault_clear = 1'b0;
		setp;
		m = '0;
		m.error_evt = 1'b1;
		pulse(m);
		tick(1);
		chk("fault err", fault, 1'b1);
		wreg(`WDIO_OFS_IRQ_STAT, 32'hf);
		wreg(`WDIO_OFS_IRQ_MASK, 32'h0);
		tick(2);
		chk("irq clr", irq, 1'b0);
		pv.fault_clear = 1'b1;
		setp;
		pv.fault_clear = 1'b0;
		setp;
		$display("fault test done");
		wreg(`WDIO_OFS_CTRL, 32'h2);
		@(posedge clk);
		seq.current_req <= 1'b1;
		tick(20);
		chk("grant off", so.current_grant, 1'b0);
		chk("permit off", so.weld_permit, 1'b0);
		pv.weld_enable = 1'b1;
		setp;
		chk("grant on", so.current_grant, 1'b1);
		chk("permit on", so.weld_permit, 1'b1);
		@(posedge clk);
		seq.current_on <= 1'b1;
		tick(3);
		chk("ind on", current_ind, 1'b1);
		seq.current_on <= 1'b0;
		tick(3);
		chk("ind off", current_ind, 1'b0);
		seq.current_req <= 1'b0;
		wreg(`WDIO_OFS_CTRL, 32'h0);
		m = '0;
		m.phase1_start = 1'b1;
		pulse(m);
		tick(12);
		chk("ind held", current_ind, 1'b1);
		m = '0;
		m.phase3_end = 1'b1;
		pulse(m);
		tick(3);
		chk("ind end", current_ind, 1'b0);
		m = '0;
		m.count_up = 1'b1;
		pulse(m);
		chk("count up", shared_out, 1'b1);
		rreg(`WDIO_OFS_WELD_COUNT);
		chk("count", r, 32'h1);
		pv.interlock_cnt_rst = 1'b1;
		setp;
		chk("clear out", so.count_clear, 1'b1);
		rreg(`WDIO_OFS_WELD_COUNT);
		chk("count clr", r, 32'h0);
		$display("indicator test done");
		wreg(`WDIO_OFS_CTRL, 32'h1);
		@(posedge clk);
		seq.current_req <= 1'b1;
		tick(3 * LC);
		chk("holdoff", so.current_grant, 1'b0);
		chk("no clear", so.count_clear, 1'b0);
		chk("no lead", shared_out, 1'b0);
		pv.interlock_cnt_rst = 1'b0;
		plc_u.drive(pv);
		n = 0;
		ls = 0;
		while (so.current_grant !== 1'b1 && n < 100) begin
			tick(1);
			n++;
			if (shared_out === 1'b1 && so.current_grant !== 1'b1)
				ls++;
		end
		if (so.current_grant !== 1'b1)
			hang = 1'b1;
		chk("lead", ls >= LC && ls <= LC + 3, 1'b1);
		chk("interlock", shared_out, 1'b1);
		seq.current_req <= 1'b0;
		seq.sched_wr_req <= 1'b1;
		pv.edit_lock = 1'b1;
		setp;
		chk("wr lock", so.sched_wr_en, 1'b0);
		pv.edit_lock = 1'b0;
		setp;
		chk("wr open", so.sched_wr_en, 1'b1);
		seq.sched_wr_req <= 1'b0;
		$display("interlock test done");
		wreg(`WDIO_OFS_CTRL, 32'h4);
		m = '0;
		m.hold_done = 1'b1;
		pulse(m);
		tick(1);
		chk("hold", hold_end, 1'b1);
		n = 0;
		while (hold_end === 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		if (hold_end === 1'b1)
			hang = 1'b1;
		chk("hold pulse", n >= HC - 3 && n <= HC + 1, 1'b1);
		wreg(`WDIO_OFS_CTRL, 32'h0);
		@(posedge clk);
		seq.start_active <= 1'b1;
		pulse(m);
		tick(HC + 10);
		chk("hold level", hold_end, 1'b1);
		seq.start_active <= 1'b0;
		tick(4);
		chk("hold drop", hold_end, 1'b0);
		$display("hold test done");
		final_report;
	end
endmodule : test_weld_controller_discrete_io
